// File: src/pabmux_map.vh
`ifndef PABMUX_MAP_VH
`define PABMUX_MAP_VH
// ----------------------------------------------------------------------
// Port and field constants
// ----------------------------------------------------------------------
// Width of each port.
`define PABMUX_PORT_W 8
// Port A bit positions.
`define PABMUX_PA_BP0 0
`define PABMUX_PA_BP1 1
`define PABMUX_PA_BP2 2
`define PABMUX_PA_BP3 3
// Port B bit positions of the alternate functions.
`define PABMUX_PB_SEL 0
`define PABMUX_PB_SCK 1
`define PABMUX_PB_MOSI 2
`define PABMUX_PB_MISO 3
`define PABMUX_PB_T0A 4
`define PABMUX_PB_T1A 5
`define PABMUX_PB_T1B 6
`define PABMUX_PB_T2A 7
// Duty select codes: static, 1/2, 1/3 and 1/4 duty.
`define PABMUX_DUTY_STATIC 2'h0
`define PABMUX_DUTY_HALF 2'h1
`define PABMUX_DUTY_THIRD 2'h2
`define PABMUX_DUTY_QUART 2'h3
// Reset value of the registered outputs other than the slave select tap.
`define PABMUX_RST_BYTE 8'h00
`define PABMUX_RST_BIT 1'h0
// Reset value of the slave select tap: released, so no transfer starts.
`define PABMUX_RST_SEL_N 1'h1
`endif

// File: src/pabmux_port_a_b_alt_function_mux.v
// What this block does
// - Port A maps back-plane and front-plane lines.
// - Upper port A overridden to LCD when enabled.
// - Lower port A overridden per enable and duty.
// - Bit 7 drives timer2 compare A when output.
// - Bit 6 drives timer1 compare B when output.
// - Bit 5 drives timer1 compare A when output.
// - Bit 4 drives timer0 compare A when output.
// - Port B pins feed pin-change sources 15..8.
// - SPI master forces bit 3 to input.
// - SPI slave forces bit 2 to input.
// - SPI slave forces bit 1 to input.
// - Forced input bit 3 keeps latch pull-up.
// - SPI slave forces select input, active low.
// - Pull-up follows override or 010 pattern.
// - Input buffer follows override, else sleep.
`timescale 1ns/10ps
`default_nettype none
`include "pabmux_map.vh"

module pabmux_port_a_b_alt_function_mux (
  input  wire       mclk_in,               // I/O clock, 125 MHz.
  input  wire       reset_in,              // Synchronous reset, active high.
  input  wire       lcd_enable_in,         // LCD controller enabled.
  input  wire [1:0] lcd_duty_sel_in,       // Multiplex duty select.
  input  wire [3:0] back_plane_line_in,    // Back-plane drive, lines 0..3.
  input  wire [3:0] front_plane_line_in,   // Front-plane drive, lines 0..3.
  input  wire       pullup_global_off_in,  // Global pull-up disable.
  input  wire       sleep_in,              // Sleep controller clamp request.
  input  wire [7:0] dir_a_in,              // Port A direction bits.
  input  wire [7:0] latch_a_in,            // Port A output latch bits.
  input  wire [7:0] dir_b_in,              // Port B direction bits.
  input  wire [7:0] latch_b_in,            // Port B output latch bits.
  input  wire       t2_compare_a_out_in,   // Timer 2 compare A waveform.
  input  wire       t2_compare_a_en_in,    // Timer 2 compare A output enabled.
  input  wire       t1_compare_b_out_in,   // Timer 1 compare B waveform.
  input  wire       t1_compare_b_en_in,    // Timer 1 compare B output enabled.
  input  wire       t1_compare_a_out_in,   // Timer 1 compare A waveform.
  input  wire       t1_compare_a_en_in,    // Timer 1 compare A output enabled.
  input  wire       t0_compare_a_out_in,   // Timer 0 compare A waveform.
  input  wire       t0_compare_a_en_in,    // Timer 0 compare A output enabled.
  input  wire       spi_on_in,             // SPI enabled.
  input  wire       spi_master_sel_in,     // SPI is master.
  input  wire       spi_master_data_in,    // Master data out, to bit 2.
  input  wire       spi_slave_data_in,     // Slave data out, to bit 3.
  input  wire       spi_clock_data_in,     // Master clock out, to bit 1.
  input  wire [7:0] pin_change_mask_in,    // Pin-change enables of sources 15..8.
  input  wire       pin_change_grp_en_in,  // Pin-change group enable.
  input  wire [7:0] pad_a_in,              // Port A pad levels.
  input  wire [7:0] pad_b_in,              // Port B pad levels.
  output reg  [7:0] pad_a_oe_out,          // Port A output driver enable.
  output reg  [7:0] pad_a_o_out,           // Port A output value.
  output reg  [7:0] pad_a_pu_out,          // Port A pull-up enable.
  output reg  [7:0] pad_a_ie_out,          // Port A digital input enable.
  output reg  [7:0] analog_pad_path_a_out, // Port A LCD level per pad.
  output reg  [7:0] analog_pad_sel_a_out,  // Port A analog path connected.
  output reg  [7:0] pad_b_oe_out,          // Port B output driver enable.
  output reg  [7:0] pad_b_o_out,           // Port B output value.
  output reg  [7:0] pad_b_pu_out,          // Port B pull-up enable.
  output reg  [7:0] pad_b_ie_out,          // Port B digital input enable.
  output reg  [7:0] port_a_in_out,         // Port A synchronised input.
  output reg  [7:0] port_b_in_out,         // Port B synchronised input.
  output reg  [7:0] pin_change_src_out,    // Sources 15..8, stage 2 tap, unfiltered.
  output reg        spi_miso_in_out,       // Master data in, from bit 3.
  output reg        spi_mosi_in_out,       // Slave data in, from bit 2.
  output reg        spi_sck_in_out,        // Slave clock in, from bit 1.
  output reg        spi_select_n_out       // Slave select, active low.
);

  // ----------------------------------------------------------------------
  // Override signal sets
  // ----------------------------------------------------------------------
  reg [7:0] pullup_ovr_en;   // Pull-up override enables.
  reg [7:0] pullup_ovr_val;  // Pull-up override values.
  reg [7:0] dir_ovr_en;      // Direction override enables.
  reg [7:0] dir_ovr_val;     // Direction override values.
  reg [7:0] outval_ovr_en;   // Output value override enables.
  reg [7:0] outval_ovr_val;  // Output value override values.
  reg [7:0] inbuf_ovr_en;    // Input buffer override enables.
  reg [7:0] inbuf_ovr_val;   // Input buffer override values.
  reg [7:0] b_pu_en;         // Port B pull-up override enables.
  reg [7:0] b_pu_val;        // Port B pull-up override values.
  reg [7:0] b_dir_en;        // Port B direction override enables.
  reg [7:0] b_dir_val;       // Port B direction override values.
  reg [7:0] b_out_en;        // Port B value override enables.
  reg [7:0] b_out_val;       // Port B value override values.
  reg [7:0] b_in_en;         // Port B input buffer override enables.
  reg [7:0] b_in_val;        // Port B input buffer override values.
  reg [3:0] bp_used;         // Back-plane lines used by the duty.
  reg       spi_master;      // SPI on as master.
  reg       spi_slave;       // SPI on as slave.
  reg [7:0] nxt_a_oe;        // Next port A driver enables.
  reg [7:0] nxt_b_oe;        // Next port B driver enables.
  integer   i;               // Bit loop index of the registered process.
  integer   j;               // Bit loop index of the combinational process.

  // Pad synchronisers: three stages, a change counts when stages 2 and 3 agree.
  reg [7:0] sync1_a_ff;
  reg [7:0] sync2_a_ff;
  reg [7:0] sync3_a_ff;
  reg [7:0] sync1_b_ff;
  reg [7:0] sync2_b_ff;
  reg [7:0] sync3_b_ff;

  // ----------------------------------------------------------------------
  // Port A overrides
  // ----------------------------------------------------------------------
  // The duty decides which back-plane lines exist, so unused ones stay GPIO.
  always @* begin
    case (lcd_duty_sel_in)
      `PABMUX_DUTY_STATIC: bp_used = 4'h1;
      `PABMUX_DUTY_HALF:   bp_used = 4'h3;
      `PABMUX_DUTY_THIRD:  bp_used = 4'h7;
      `PABMUX_DUTY_QUART:  bp_used = 4'hF;
      default:             bp_used = 4'h1;
    endcase
    // Lower pins need the duty as well, bit 0 only the enable.
    pullup_ovr_en[3:0] = {4{lcd_enable_in}} & bp_used;
    pullup_ovr_en[7:4] = {4{lcd_enable_in}};
    pullup_ovr_val     = 8'h00;
    dir_ovr_en         = pullup_ovr_en;
    dir_ovr_val        = 8'h00;
    outval_ovr_en      = 8'h00;
    outval_ovr_val     = 8'h00;
    inbuf_ovr_en       = pullup_ovr_en;
    inbuf_ovr_val      = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Port B overrides
  // ----------------------------------------------------------------------
  always @* begin
    spi_master = spi_on_in & spi_master_sel_in;
    spi_slave  = spi_on_in & ~spi_master_sel_in;
    // Forced inputs keep the latch-driven pull-up, gated by the global off.
    b_pu_en  = 8'h00;
    b_pu_val = 8'h00;
    b_dir_en = 8'h00;
    b_dir_val = 8'h00;
    b_pu_en[`PABMUX_PB_MISO] = spi_master;
    b_pu_en[`PABMUX_PB_MOSI] = spi_slave;
    b_pu_en[`PABMUX_PB_SCK]  = spi_slave;
    b_pu_en[`PABMUX_PB_SEL]  = spi_slave;
    b_pu_val[3:0] = latch_b_in[3:0] & {4{~pullup_global_off_in}};
    b_dir_en[`PABMUX_PB_MISO] = spi_master;
    b_dir_en[`PABMUX_PB_MOSI] = spi_slave;
    b_dir_en[`PABMUX_PB_SCK]  = spi_slave;
    b_dir_en[`PABMUX_PB_SEL]  = spi_slave;
    // Value overrides: SPI drives pins it owns, timers only when enabled.
    b_out_en  = {t2_compare_a_en_in, t1_compare_b_en_in, t1_compare_a_en_in,
                 t0_compare_a_en_in, spi_slave, spi_master, spi_master, 1'h0};
    b_out_val = {t2_compare_a_out_in, t1_compare_b_out_in, t1_compare_a_out_in,
                 t0_compare_a_out_in, spi_slave_data_in, spi_master_data_in,
                 spi_clock_data_in, 1'h0};
    // Enabled pin-change sources keep the input buffer alive in sleep.
    b_in_en  = pin_change_mask_in & {8{pin_change_grp_en_in}};
    b_in_val = 8'hFF;
  end

  // ----------------------------------------------------------------------
  // Driver enables
  // ----------------------------------------------------------------------
  // Timer outputs reach the pin only through the direction bit.
  always @* begin
    // A loop index of its own keeps this process from sharing a variable.
    for (j = 0; j < `PABMUX_PORT_W; j = j + 1) begin
      nxt_a_oe[j] = dir_ovr_en[j] ? dir_ovr_val[j] : dir_a_in[j];
      nxt_b_oe[j] = b_dir_en[j] ? b_dir_val[j] : dir_b_in[j];
    end
  end

  // ----------------------------------------------------------------------
  // Registered pad control
  // ----------------------------------------------------------------------
  // Outputs are registered: one cycle of latency is traded for clean pins.
  always @(posedge mclk_in) begin
    if (reset_in) begin
      pad_a_oe_out          <= `PABMUX_RST_BYTE;
      pad_a_o_out           <= `PABMUX_RST_BYTE;
      pad_a_pu_out          <= `PABMUX_RST_BYTE;
      pad_a_ie_out          <= `PABMUX_RST_BYTE;
      analog_pad_path_a_out <= `PABMUX_RST_BYTE;
      analog_pad_sel_a_out  <= `PABMUX_RST_BYTE;
      pad_b_oe_out          <= `PABMUX_RST_BYTE;
      pad_b_o_out           <= `PABMUX_RST_BYTE;
      pad_b_pu_out          <= `PABMUX_RST_BYTE;
      pad_b_ie_out          <= `PABMUX_RST_BYTE;
    end else begin
      for (i = 0; i < `PABMUX_PORT_W; i = i + 1) begin
        pad_a_oe_out[i] <= nxt_a_oe[i];
        pad_a_o_out[i]  <= outval_ovr_en[i] ? outval_ovr_val[i] : latch_a_in[i];
        pad_a_pu_out[i] <= pullup_ovr_en[i] ? pullup_ovr_val[i] :
                           ({dir_a_in[i], latch_a_in[i], pullup_global_off_in} == 3'h2);
        pad_a_ie_out[i] <= inbuf_ovr_en[i] ? inbuf_ovr_val[i] : ~sleep_in;
        pad_b_oe_out[i] <= nxt_b_oe[i];
        pad_b_o_out[i]  <= b_out_en[i] ? b_out_val[i] : latch_b_in[i];
        pad_b_pu_out[i] <= b_pu_en[i] ? b_pu_val[i] :
                           ({dir_b_in[i], latch_b_in[i], pullup_global_off_in} == 3'h2);
        pad_b_ie_out[i] <= b_in_en[i] ? b_in_val[i] : ~sleep_in;
      end
      // Back-plane on bits 0..3, front-plane on bits 4..7.
      analog_pad_path_a_out <= {front_plane_line_in, back_plane_line_in};
      analog_pad_sel_a_out  <= pullup_ovr_en;
    end
  end

  // ----------------------------------------------------------------------
  // Pad input synchronisers and alternate input taps
  // ----------------------------------------------------------------------
  // Stage 1 feeds only stage 2; consumers look at stages 2 and 3.
  always @(posedge mclk_in) begin
    if (reset_in) begin
      sync1_a_ff <= `PABMUX_RST_BYTE;
      sync2_a_ff <= `PABMUX_RST_BYTE;
      sync3_a_ff <= `PABMUX_RST_BYTE;
      sync1_b_ff <= `PABMUX_RST_BYTE;
      sync2_b_ff <= `PABMUX_RST_BYTE;
      sync3_b_ff <= `PABMUX_RST_BYTE;
      port_a_in_out      <= `PABMUX_RST_BYTE;
      port_b_in_out      <= `PABMUX_RST_BYTE;
      pin_change_src_out <= `PABMUX_RST_BYTE;
      spi_miso_in_out    <= `PABMUX_RST_BIT;
      spi_mosi_in_out    <= `PABMUX_RST_BIT;
      spi_sck_in_out     <= `PABMUX_RST_BIT;
      spi_select_n_out   <= `PABMUX_RST_SEL_N;
    end else begin
      sync1_a_ff <= pad_a_in & pad_a_ie_out;
      sync2_a_ff <= sync1_a_ff;
      sync3_a_ff <= sync2_a_ff;
      sync1_b_ff <= pad_b_in & pad_b_ie_out;
      sync2_b_ff <= sync1_b_ff;
      sync3_b_ff <= sync2_b_ff;
      // A bit changes only once stages 2 and 3 agree.
      port_a_in_out <= (sync2_a_ff & sync3_a_ff) | (port_a_in_out & (sync2_a_ff | sync3_a_ff));
      port_b_in_out <= (sync2_b_ff & sync3_b_ff) | (port_b_in_out & (sync2_b_ff | sync3_b_ff));
      pin_change_src_out <= sync2_b_ff;
      spi_miso_in_out    <= sync2_b_ff[`PABMUX_PB_MISO];
      spi_mosi_in_out    <= sync2_b_ff[`PABMUX_PB_MOSI];
      spi_sck_in_out     <= sync2_b_ff[`PABMUX_PB_SCK];
      // Slave select reads high (idle) unless the SPI is a slave.
      spi_select_n_out   <= spi_slave ? sync2_b_ff[`PABMUX_PB_SEL] : 1'h1;
    end
  end

endmodule
`default_nettype wire

// File: testbench/pabmux_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Override checker: pad controls lag their causes by one edge.
// ----------------------------------------------------------
module pabmux_chk (
  input wire       mclk_in,
  input wire       reset_in,
  input wire       lcd_enable_in,
  input wire [1:0] lcd_duty_sel_in,
  input wire [3:0] back_plane_line_in,
  input wire [3:0] front_plane_line_in,
  input wire       pullup_global_off_in,
  input wire [7:0] dir_a_in,
  input wire [7:0] latch_a_in,
  input wire [7:0] dir_b_in,
  input wire [7:0] latch_b_in,
  input wire       spi_on_in,
  input wire       spi_master_sel_in,
  input wire [7:0] pad_a_oe_out,
  input wire [7:0] pad_a_pu_out,
  input wire [7:0] pad_a_ie_out,
  input wire [7:0] analog_pad_path_a_out,
  input wire [7:0] analog_pad_sel_a_out,
  input wire [7:0] pad_b_oe_out,
  input wire [7:0] pad_b_pu_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // The first edge after release still shows reset values, so it is skipped.
  sequence s_live; !$past(reset_in); endsequence
  sequence s_master; s_live ##0 $past(spi_on_in && spi_master_sel_in); endsequence
  sequence s_slave; s_live ##0 $past(spi_on_in && !spi_master_sel_in); endsequence
  chk_upper_lcd_own: assert property (s_live |->
    analog_pad_sel_a_out[7:4] == {4{$past(lcd_enable_in)}}) else $error("upper lcd ownership");
  chk_lower_duty_own: assert property (s_live |-> analog_pad_sel_a_out[3:0] ==
    {$past(lcd_enable_in) && $past(lcd_duty_sel_in) == 2'h3, $past(lcd_enable_in) &&
    $past(lcd_duty_sel_in) >= 2'h2, $past(lcd_enable_in) && $past(lcd_duty_sel_in) >= 2'h1,
    $past(lcd_enable_in)}) else $error("lower lcd ownership");
  chk_owned_pin_quiet: assert property (
    (analog_pad_sel_a_out & (pad_a_oe_out | pad_a_pu_out | pad_a_ie_out)) == 8'h00)
    else $error("owned pad not quiet");
  chk_lcd_levels: assert property (s_live |-> analog_pad_path_a_out ==
    {$past(front_plane_line_in), $past(back_plane_line_in)}) else $error("lcd level map");
  chk_master_miso_in: assert property (s_master |-> !pad_b_oe_out[3] &&
    pad_b_pu_out[3] == $past(latch_b_in[3] && !pullup_global_off_in)) else $error("miso force");
  chk_slave_pins_in: assert property (s_slave |-> pad_b_oe_out[2:0] == 3'h0 &&
    pad_b_pu_out[2:0] == $past(latch_b_in[2:0] & {3{!pullup_global_off_in}}))
    else $error("slave pins not forced to input");
  chk_timer_dir: assert property (s_live |->
    pad_b_oe_out[7:4] == $past(dir_b_in[7:4])) else $error("timer pin direction");
  chk_pullup_pattern: assert property (s_live |-> (pad_a_pu_out & ~analog_pad_sel_a_out) ==
    ($past(~dir_a_in & latch_a_in & {8{!pullup_global_off_in}}) & ~analog_pad_sel_a_out))
    else $error("pull-up pattern");
endmodule
bind pabmux_port_a_b_alt_function_mux pabmux_chk pabmux_chk_inst (.*);
`default_nettype wire

// File: testbench/pabmux_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Port B wire as the timers, SPI partner and pin-change logic see it.
// ----------------------------------------------------------
module pabmux_far_side (
  input  wire       mclk_in,
  input  wire [7:0] oe_in,
  input  wire [7:0] o_in,
  input  wire [7:0] pu_in,
  output wire [7:0] pad_out
);
  reg [7:0] last_ff = 8'h00; // Last level driven onto each pin.
  integer k; // Bit loop index.
  // Remember the drive so that a released pin never shows a stale copy.
  // Only a known driving enable updates a bit, so an unknown enable before
  // the first reset edge cannot leave an unknown level on an idle pin.
  always @(posedge mclk_in) begin
    for (k = 0; k < 8; k = k + 1) begin
      if (oe_in[k] === 1'b1) begin
        last_ff[k] <= o_in[k];
      end
    end
  end
  // A floating pin without pull-up shows the inverse of its last drive.
  assign pad_out = (oe_in & o_in) | (~oe_in & (pu_in | ~last_ff));
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  // ----------------------------------------------------------
  // Nets named after the design ports.
  // ----------------------------------------------------------
  logic mclk_in = 0, reset_in = 1, lcd_enable_in, pullup_global_off_in, sleep_in;
  logic t2_compare_a_out_in, t2_compare_a_en_in, t1_compare_b_out_in, t1_compare_b_en_in;
  logic t1_compare_a_out_in, t1_compare_a_en_in, t0_compare_a_out_in, t0_compare_a_en_in;
  logic spi_on_in, spi_master_sel_in, spi_master_data_in, spi_slave_data_in, spi_clock_data_in;
  logic pin_change_grp_en_in, spi_miso_in_out, spi_mosi_in_out, spi_sck_in_out, spi_select_n_out;
  logic [1:0] lcd_duty_sel_in;
  logic [3:0] back_plane_line_in, front_plane_line_in;
  logic [7:0] dir_a_in, latch_a_in, dir_b_in, latch_b_in, pin_change_mask_in, pad_a_in, pad_b_in;
  logic [7:0] pad_a_oe_out, pad_a_o_out, pad_a_pu_out, pad_a_ie_out, analog_pad_path_a_out;
  logic [7:0] analog_pad_sel_a_out, pad_b_oe_out, pad_b_o_out, pad_b_pu_out, pad_b_ie_out;
  logic [7:0] port_a_in_out, port_b_in_out, pin_change_src_out;
  int miscompares = 0, num_checks = 0;
  pabmux_port_a_b_alt_function_mux pabmux_port_a_b_alt_function_mux_inst (.*);
  pabmux_far_side pabmux_far_side_inst (.mclk_in(mclk_in), .oe_in(pad_b_oe_out),
    .o_in(pad_b_o_out), .pu_in(pad_b_pu_out), .pad_out(pad_b_in));
  initial forever #4 mclk_in = ~mclk_in;
  // ----------------------------------------------------------
  // Stimulus and reference model.
  // ----------------------------------------------------------
  // Every input but the clock, reset and pad_b_in is drawn at random at once.
  task automatic stim();
    logic [95:0] r;
    r = {$urandom, $urandom, $urandom};
    {lcd_enable_in, lcd_duty_sel_in, back_plane_line_in, front_plane_line_in, pullup_global_off_in,
     sleep_in, dir_a_in, latch_a_in, dir_b_in, latch_b_in, t2_compare_a_out_in, t2_compare_a_en_in,
     t1_compare_b_out_in, t1_compare_b_en_in, t1_compare_a_out_in, t1_compare_a_en_in,
     t0_compare_a_out_in, t0_compare_a_en_in, spi_on_in, spi_master_sel_in, spi_master_data_in,
     spi_slave_data_in, spi_clock_data_in, pin_change_mask_in, pin_change_grp_en_in,
     pad_a_in} = r[74:0];
  endtask
  // Compares once the filtered inputs have settled, eight edges on.
  task automatic check_all();
    logic [7:0] own, frc, ieb, pu;
    logic mst, slv;
    logic [3:0] tmr, spo;
    own = {8{lcd_enable_in}};
    for (int i = 1; i < 4; i++) own[i] = lcd_enable_in && int'(lcd_duty_sel_in) >= i;
    mst = spi_on_in && spi_master_sel_in;
    slv = spi_on_in && !spi_master_sel_in;
    frc = {4'h0, mst, slv, slv, slv};
    ieb = (pin_change_mask_in & {8{pin_change_grp_en_in}}) | {8{!sleep_in}};
    pu = {8{!pullup_global_off_in}};
    tmr = {t2_compare_a_en_in ? t2_compare_a_out_in : latch_b_in[7],
           t1_compare_b_en_in ? t1_compare_b_out_in : latch_b_in[6],
           t1_compare_a_en_in ? t1_compare_a_out_in : latch_b_in[5],
           t0_compare_a_en_in ? t0_compare_a_out_in : latch_b_in[4]};
    spo = {slv ? spi_slave_data_in : latch_b_in[3],
           mst ? spi_master_data_in : latch_b_in[2],
           mst ? spi_clock_data_in : latch_b_in[1],
           latch_b_in[0]};
    `CHK("sel_a", own, analog_pad_sel_a_out)
    `CHK("path_a", {front_plane_line_in, back_plane_line_in}, analog_pad_path_a_out)
    `CHK("oe_a", dir_a_in & ~own, pad_a_oe_out)
    `CHK("pu_a", ~dir_a_in & latch_a_in & pu & ~own, pad_a_pu_out)
    `CHK("ie_a", {8{!sleep_in}} & ~own, pad_a_ie_out)
    `CHK("in_a", pad_a_in & {8{!sleep_in}} & ~own, port_a_in_out)
    `CHK("oe_b", dir_b_in & ~frc, pad_b_oe_out)
    `CHK("pu_b", (frc | ~dir_b_in) & latch_b_in & pu, pad_b_pu_out)
    `CHK("ie_b", ieb, pad_b_ie_out)
    `CHK("src_b", pad_b_in & ieb, pin_change_src_out)
    `CHK("in_b", pad_b_in & ieb, port_b_in_out)
    `CHK("sel_n", slv ? pad_b_in[0] & ieb[0] : 1'h1, spi_select_n_out)
    `CHK("o_b", tmr, pad_b_o_out[7:4])
    if (mst) `CHK("mosi_o", spi_master_data_in, pad_b_o_out[2])
    `CHK("o_b_low", spo, pad_b_o_out[3:0])
    `CHK("o_a", latch_a_in, pad_a_o_out)
    `CHK("miso_i", pad_b_in[3] & ieb[3], spi_miso_in_out)
    `CHK("mosi_i", pad_b_in[2] & ieb[2], spi_mosi_in_out)
    `CHK("sck_i", pad_b_in[1] & ieb[1], spi_sck_in_out)
  endtask
  task automatic run(int n);
    repeat (n) begin
      stim();
      repeat (8) @(posedge mclk_in);
      #1;
      check_all();
    end
  endtask
  // Reset leaves port B drivers off, no port A pad owned by the LCD and the slave select released.
  task automatic rst_chk();
    `CHK("rst_sel_n", 1'h1, spi_select_n_out)
    `CHK("rst_sel_a", 8'h00, analog_pad_sel_a_out)
    `CHK("rst_oe_b", 8'h00, pad_b_oe_out)
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Main sequence with a second reset in mid-run, and a watchdog.
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'hA598));
    stim();
    repeat (6) @(posedge mclk_in);
    #1;
    rst_chk();
    reset_in = 0;
    run(300);
    reset_in = 1;
    repeat (2) @(posedge mclk_in);
    #1;
    rst_chk();
    reset_in = 0;
    run(100);
    end_of_test();
  end
  initial begin
    #60000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
